// file: include/sbp_pkg.sv
`default_nettype none
package sbp_pkg;
  // register offsets (indices; byte address is four times the index)
  localparam logic [2:0] OFF_CONTROL_A = 3'h0;
  localparam logic [2:0] OFF_CONTROL_B = 3'h1;
  localparam logic [2:0] OFF_IRQ_ENABLE = 3'h2;
  localparam logic [2:0] OFF_IRQ_FLAGS = 3'h3;
  localparam logic [2:0] OFF_DATA_PORT = 3'h4;
  // control_a fields
  localparam int CA_ENABLE = 0;
  localparam int CA_SPEED_DOUBLE = 4;
  localparam int CA_CONTROLLER = 5;
  localparam int CA_BIT_ORDER = 6;
  // control_b fields
  localparam int CB_MODE_LO = 0;
  localparam int CB_SELECT_IGNORE = 2;
  localparam int CB_WAIT_RX = 6;
  localparam int CB_BUFFER_EN = 7;
  // irq_enable fields
  localparam int IE_TRANSFER = 0;
  localparam int IE_SELECT = 4;
  localparam int IE_EMPTY = 5;
  localparam int IE_TXC = 6;
  localparam int IE_RXC = 7;
  // irq flag fields (normal / buffered views)
  localparam int FN_TRANSFER = 7;
  localparam int FN_COLLISION = 6;
  localparam int FB_OVERFLOW = 0;
  localparam int FB_SELECT = 4;
  localparam int FB_EMPTY = 5;
  localparam int FB_TXC = 6;
  localparam int FB_RXC = 7;
  // reset values and writable masks
  localparam logic [7:0] RST_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_CONTROL_B = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] MASK_CONTROL_A = 8'h77;
  localparam logic [7:0] MASK_CONTROL_B = 8'hC7;
  localparam logic [7:0] MASK_IRQ_ENABLE = 8'hF1;
  // transfer modes
  typedef enum logic [1:0] {
    SBP_MODE0 = 2'h0,
    SBP_MODE1 = 2'h1,
    SBP_MODE2 = 2'h2,
    SBP_MODE3 = 2'h3
  } sbp_mode_t;
  localparam logic [2:0] BITS_LAST = 3'h7;
endpackage : sbp_pkg
`default_nettype wire

// file: hdl/sbp_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for one pin level
module sbp_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // level
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sbp_sync_t;
  sbp_sync_t st;
  sbp_sync_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.s1 = pin;
      next_st.s2 = st.s1;
    end
  end

  // register; reset level is the pin's idle level so no false edge follows
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '{s1: RESET_LEVEL, s2: RESET_LEVEL};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.s2;
endmodule : sbp_sync
`default_nettype wire

// file: hdl/sbp_rx_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// two-entry receive queue with overflow report
module sbp_rx_fifo (
  // clock
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // control
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  // status
  output logic [7:0] head,
  output logic not_empty,
  output logic overflow
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic [1:0] count;
  } sbp_fifo_t;
  sbp_fifo_t st;
  sbp_fifo_t next_st;
  logic do_pop;

  // pop shifts entry 1 down; push appends at count
  always_comb begin
    next_st = st;
    do_pop = pop && (st.count != 2'h0);
    overflow = 1'b0;
    if (ce) begin
      if (flush) begin
        next_st.count = 2'h0;
      end else begin
        if (do_pop) begin
          next_st.mem[0] = st.mem[1];
          next_st.count = st.count - 2'h1;
        end
        if (push) begin
          if (next_st.count == 2'h2) begin
            overflow = 1'b1;
          end else begin
            next_st.mem[next_st.count[0]] = push_data;
            next_st.count = next_st.count + 2'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign head = st.mem[0];
  assign not_empty = (st.count != 2'h0);
endmodule : sbp_rx_fifo
`default_nettype wire

// file: hdl/sbp_port.sv
// Overview of operation
// - buffer enable adds buffers and flags
// - wait bit 0: first byte is dummy
// - wait bit 0: writes go to holding buffer
// - write while buffer full is dropped
// - empty flag drops on write, rises on copy
// - receive flag one cycle after empty rises
// - transfer-complete one cycle after receive flag
// - wait bit 1: select high write loads shifter
// - select, data in and clock always inputs
// - data out driven only while selected
// - select rise resets the shifter at once
// - four phase/polarity modes, opposite edges
// - mode encoding and idle clock level
// - clock exported as synchronous level event
// - one interrupt from mode dependent sources
// - request holds while flag and enable set
// - bit order: 0 MSB first, 1 LSB first
// - select low in controller mode drops it
// - any accepted buffered data write clears empty flag
// - overflow on third byte, read clears
// - receive flag follows unread bytes
`timescale 1ns/100ps
`default_nettype none
module sbp_port (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic ss_n_in,
  input wire logic miso_dir_out,
  output logic miso_out,
  output logic miso_oe,
  // event and interrupt
  output logic sck_event,
  output logic irq
);
  typedef struct packed {
    logic [7:0] control_a;
    logic [7:0] control_b;
    logic [7:0] irq_enable;
    logic flag_transfer;
    logic flag_collision;
    logic flag_select;
    logic flag_empty;
    logic flag_txc;
    logic flag_overflow;
    logic rxc_pend;
    logic txc_pend;
    logic holding_full;
    logic [7:0] holding;
    logic [7:0] shifter;
    logic [7:0] rx_shift;
    logic [7:0] normal_rx;
    logic [2:0] bit_cnt;
    logic busy;
    logic load_pend;
    logic sent_data;
    logic sck_q;
    logic ss_q;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic miso;
    logic miso_oe;
    logic sck_event;
    logic irq;
  } sbp_state_t;
  sbp_state_t st;
  sbp_state_t next_st;

  logic sck_s;
  logic mosi_s;
  logic ss_s;
  logic [7:0] fifo_head;
  logic fifo_ne;
  logic fifo_ovf;
  logic fifo_push;
  logic fifo_pop;
  logic [7:0] fifo_data;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: pins are inputs in every mode
  sbp_sync #(.RESET_LEVEL(1'b0)) u_sync_sck (.clk(clk), .reset_n(reset_n), .ce(clk_en),
    .pin(sck_in), .level(sck_s));
  sbp_sync u_sync_mosi (.clk(clk), .reset_n(reset_n), .ce(clk_en), .pin(mosi_in),
    .level(mosi_s));
  sbp_sync u_sync_ss (.clk(clk), .reset_n(reset_n), .ce(clk_en), .pin(ss_n_in),
    .level(ss_s));

  ////////////////////////////////////////////////////////////////////////////
  // receive queue used in buffered operation
  sbp_rx_fifo u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .ce(clk_en),
    .flush(!st.control_b[sbp_pkg::CB_BUFFER_EN]),
    .push(fifo_push),
    .push_data(fifo_data),
    .pop(fifo_pop),
    .head(fifo_head),
    .not_empty(fifo_ne),
    .overflow(fifo_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic buffered;
    logic enabled;
    logic slave;
    logic lsb_first;
    logic [1:0] mode;
    logic cpha;
    logic sck_rise;
    logic sck_fall;
    logic lead;
    logic trail;
    logic sample_edge;
    logic setup_edge;
    logic access;
    logic wr;
    logic rd;
    logic [2:0] idx;
    logic [7:0] wb;
    logic [7:0] rx_next;
    logic done;
    logic [7:0] flags_view;
    buffered = st.control_b[sbp_pkg::CB_BUFFER_EN];
    enabled = st.control_a[sbp_pkg::CA_ENABLE];
    slave = !st.control_a[sbp_pkg::CA_CONTROLLER];
    lsb_first = st.control_a[sbp_pkg::CA_BIT_ORDER];
    mode = st.control_b[sbp_pkg::CB_MODE_LO +: 2];
    cpha = mode[0];
    sck_rise = sck_s && !st.sck_q;
    sck_fall = !sck_s && st.sck_q;
    // leading edge rises for modes 0/1, falls for modes 2/3
    lead = mode[1] ? sck_fall : sck_rise;
    trail = mode[1] ? sck_rise : sck_fall;
    sample_edge = cpha ? trail : lead;
    setup_edge = cpha ? lead : trail;
    access = psel && penable;
    wr = access && pwrite;
    rd = access && !pwrite;
    idx = (paddr[31:5] != 27'h0) ? 3'h7 : paddr[4:2]; // high address bits map nowhere
    wb = pwdata[7:0];
    rx_next = lsb_first ? {mosi_s, st.rx_shift[7:1]} : {st.rx_shift[6:0], mosi_s};
    done = 1'b0;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    fifo_data = st.rx_shift;
    flags_view = buffered ?
      {fifo_ne, st.flag_txc, st.flag_empty, st.flag_select, 3'h0,
       st.flag_overflow} :
      {st.flag_transfer, st.flag_collision, 6'h00};
    next_st = st;
    if (clk_en) begin
      next_st.sck_q = sck_s;
      next_st.ss_q = ss_s;
      next_st.rxc_pend = 1'b0;
      next_st.txc_pend = 1'b0;
      // apb: zero-wait answer, unmapped offsets error
      next_st.pready = psel && !penable;
      next_st.pslverr = psel && !penable && (idx > 3'h4);
      if (psel && !penable) begin
        unique case (idx)
          sbp_pkg::OFF_CONTROL_A: next_st.prdata = {24'h0, st.control_a};
          sbp_pkg::OFF_CONTROL_B: next_st.prdata = {24'h0, st.control_b};
          sbp_pkg::OFF_IRQ_ENABLE: next_st.prdata = {24'h0, st.irq_enable};
          sbp_pkg::OFF_IRQ_FLAGS: next_st.prdata = {24'h0, flags_view};
          sbp_pkg::OFF_DATA_PORT: next_st.prdata = {24'h0, buffered ? fifo_head : st.normal_rx};
          default: next_st.prdata = 32'h0000_0000;
        endcase
      end
      // delayed flag chain; byte is queued a cycle after the empty flag rises
      if (st.rxc_pend) begin
        next_st.txc_pend = !st.holding_full && !st.sent_data;
        fifo_push = 1'b1;
      end
      if (st.txc_pend) begin
        next_st.flag_txc = 1'b1;
      end
      // slave shifter
      if (enabled && slave) begin
        if (ss_s) begin
          next_st.busy = 1'b0;
          next_st.bit_cnt = 3'h0;
          if (st.load_pend) begin
            next_st.shifter = st.holding;
            next_st.load_pend = 1'b0;
            next_st.holding_full = 1'b0;
            next_st.flag_empty = 1'b1;
          end
        end else begin
          if (st.ss_q && !cpha) begin
            next_st.miso = lsb_first ? st.shifter[0] : st.shifter[7];
          end
          if (setup_edge && (st.busy || cpha)) begin
            next_st.miso = lsb_first ? st.shifter[0] : st.shifter[7];
          end
          if (sample_edge) begin
            next_st.busy = 1'b1;
            next_st.rx_shift = rx_next;
            next_st.shifter = lsb_first ? {1'b0, st.shifter[7:1]} : {st.shifter[6:0], 1'b0};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == sbp_pkg::BITS_LAST) begin
              done = 1'b1;
              next_st.busy = 1'b0;
            end
          end
        end
      end
      if (done) begin
        if (buffered) begin
          if (st.holding_full) begin
            next_st.shifter = st.holding;
            next_st.holding_full = 1'b0;
            next_st.flag_empty = 1'b1;
            next_st.sent_data = 1'b1;
          end else begin
            next_st.shifter = rx_next;
            next_st.sent_data = 1'b0;
          end
          next_st.rxc_pend = 1'b1;
        end else begin
          next_st.normal_rx = rx_next;
          next_st.shifter = rx_next;
          next_st.flag_transfer = 1'b1;
        end
      end
      if (fifo_ovf) begin
        next_st.flag_overflow = 1'b1;
      end
      // register writes; flag sets above win over clears here
      if (wr) begin
        unique case (idx)
          sbp_pkg::OFF_CONTROL_A: next_st.control_a = wb & sbp_pkg::MASK_CONTROL_A;
          sbp_pkg::OFF_CONTROL_B: next_st.control_b = wb & sbp_pkg::MASK_CONTROL_B;
          sbp_pkg::OFF_IRQ_ENABLE: next_st.irq_enable = wb & sbp_pkg::MASK_IRQ_ENABLE;
          sbp_pkg::OFF_IRQ_FLAGS: begin
            if (buffered) begin
              if (wb[sbp_pkg::FB_TXC] && !st.txc_pend) next_st.flag_txc = 1'b0;
              if (wb[sbp_pkg::FB_SELECT]) next_st.flag_select = 1'b0;
              if (wb[sbp_pkg::FB_OVERFLOW] && !fifo_ovf) next_st.flag_overflow = 1'b0;
              if (wb[sbp_pkg::FB_RXC]) fifo_pop = 1'b1;
            end else begin
              if (wb[sbp_pkg::FN_TRANSFER] && !done) next_st.flag_transfer = 1'b0;
              if (wb[sbp_pkg::FN_COLLISION]) next_st.flag_collision = 1'b0;
            end
          end
          sbp_pkg::OFF_DATA_PORT: begin
            if (buffered) begin
              if (st.holding_full && !st.flag_empty) begin
                next_st.holding = st.holding;
              end else if (st.control_b[sbp_pkg::CB_WAIT_RX] && ss_s && !st.load_pend &&
                           !st.sent_data && !st.holding_full) begin
                next_st.holding = wb;
                next_st.holding_full = 1'b1;
                next_st.load_pend = 1'b1;
                next_st.flag_empty = 1'b0;
              end else begin
                next_st.holding = wb;
                next_st.holding_full = 1'b1;
                next_st.flag_empty = 1'b0;
              end
            end else if (st.busy || !ss_s && slave) begin
              next_st.flag_collision = 1'b1;
            end else begin
              next_st.shifter = wb;
            end
          end
          default: next_st.holding = st.holding;
        endcase
      end
      if (rd && idx == sbp_pkg::OFF_DATA_PORT) begin
        if (buffered) begin
          fifo_pop = 1'b1;
          if (!fifo_ovf) next_st.flag_overflow = 1'b0;
        end
        if (!buffered && !done) next_st.flag_transfer = 1'b0;
      end
      // select taken by another master; after the writes so the set wins
      if (!slave && enabled && !st.control_b[sbp_pkg::CB_SELECT_IGNORE] && !ss_s) begin
        next_st.control_a[sbp_pkg::CA_CONTROLLER] = 1'b0;
        next_st.flag_transfer = 1'b1;
        next_st.flag_select = 1'b1;
      end
      // normal operation keeps the holding buffer idle
      if (!buffered) begin
        next_st.holding_full = 1'b0;
        next_st.load_pend = 1'b0;
      end
      // miso drive only while selected and pin direction is output
      next_st.miso_oe = enabled && slave && !ss_s && miso_dir_out;
      next_st.sck_event = sck_s;
      // interrupt request
      next_st.irq = buffered ?
        |(next_st.irq_enable[7:4] & {fifo_ne | fifo_push, next_st.flag_txc,
          next_st.flag_empty, next_st.flag_select}) :
        next_st.irq_enable[sbp_pkg::IE_TRANSFER] &
          (next_st.flag_transfer | next_st.flag_collision);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
      st.control_a <= sbp_pkg::RST_CONTROL_A;
      st.control_b <= sbp_pkg::RST_CONTROL_B;
      st.irq_enable <= sbp_pkg::RST_IRQ_ENABLE;
      st.sck_q <= 1'b0;
      st.ss_q <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign miso_out = st.miso;
  assign miso_oe = st.miso_oe;
  assign sck_event = st.sck_event;
  assign irq = st.irq;
endmodule : sbp_port
`default_nettype wire

// file: sim/sbp_spi_master.sv
`timescale 1ns/100ps
`default_nettype none
// behavioural spi bus master that frames every byte with select
module sbp_spi_master (
  // clock
  input wire logic clk,
  // configuration
  input wire logic [1:0] mode,
  input wire logic lsb_first,
  // serial pins
  output logic sck,
  output logic mosi,
  output logic ss_n,
  input wire logic miso
);
  // 80 ns half period of the 160 ns link clock
  localparam int HALF = 8;
  // pins idle with select high
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  //////////////////////////////////////////////////////////////////////////////////////////////
  // one framed transfer; fewer than eight bits aborts the frame
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    int b;
    rx = 8'h00;
    sck <= mode[1];
    idle(HALF);
    ss_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      b = lsb_first ? i : 7 - i;
      if (!mode[0])
        mosi <= tx[b];
      idle(HALF);
      sck <= ~mode[1];
      if (mode[0])
        mosi <= tx[b];
      else
        rx[b] = miso;
      idle(HALF);
      sck <= mode[1];
      if (mode[0])
        rx[b] = miso;
    end
    idle(HALF);
    ss_n <= 1'b1;
    mosi <= ~mosi;
    idle(HALF);
  endtask : xfer
  // select pulled low with no clock, as another master would
  task automatic select_low(input int n);
    ss_n <= 1'b0;
    idle(n);
    ss_n <= 1'b1;
    idle(HALF);
  endtask : select_low
endmodule : sbp_spi_master
`default_nettype wire

// file: sim/sbp_checker.sv
`timescale 1ns/100ps
`default_nettype none
// port level checks of the spi port
module sbp_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial and event
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic miso_dir_out,
  input wire logic miso_oe,
  input wire logic sck_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic unmapped;
  // address outside the five mapped words
  assign unmapped = (paddr[31:5] != 27'h0) || (paddr[4:2] > 3'h4);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> s_access;
  endproperty
  a_answer: assert property (p_answer) else $error("ready missing after setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err_map;
    s_setup ##0 unmapped |=> pslverr;
  endproperty
  a_err_map: assert property (p_err_map) else $error("no error on unmapped address");
  property p_err_ok;
    s_setup ##0 !unmapped |=> !pslverr;
  endproperty
  a_err_ok: assert property (p_err_ok) else $error("error on mapped address");
  property p_zero;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("read data upper bits set");
  property p_deselect;
    ss_n_in [*4] |-> !miso_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("data out driven while deselected");
  property p_dir;
    !miso_dir_out [*3] |-> !miso_oe;
  endproperty
  a_dir: assert property (p_dir) else $error("data out driven while direction input");
  property p_abort;
    $rose(ss_n_in) |-> ##[1:4] !miso_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("data out kept after select rise");
  property p_follow;
    $stable(sck_in) [*5] |-> sck_event == sck_in;
  endproperty
  a_follow: assert property (p_follow) else $error("clock event not following clock");
  property p_hold;
    $changed(sck_event) |=> $stable(sck_event);
  endproperty
  a_hold: assert property (p_hold) else $error("clock event level too short");
endmodule : sbp_checker
bind sbp_port sbp_checker u_sbp_checker (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sck_in(sck_in), .ss_n_in(ss_n_in), .miso_dir_out(miso_dir_out), .miso_oe(miso_oe),
  .sck_event(sck_event));
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [2:0] CA = sbp_pkg::OFF_CONTROL_A;
  localparam logic [2:0] CB = sbp_pkg::OFF_CONTROL_B;
  localparam logic [2:0] IE = sbp_pkg::OFF_IRQ_ENABLE;
  localparam logic [2:0] FL = sbp_pkg::OFF_IRQ_FLAGS;
  localparam logic [2:0] DP = sbp_pkg::OFF_DATA_PORT;
  logic clk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic sck, mosi, ss_n, miso_dir_out, miso_out, miso_oe, miso_line, miso_float;
  logic sck_event, irq, lsb_cfg;
  logic [1:0] mode_cfg;
  int err_total, n_checks, cyc;
  sbp_port u_sbp_port (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(sck), .mosi_in(mosi), .ss_n_in(ss_n),
    .miso_dir_out(miso_dir_out), .miso_out(miso_out), .miso_oe(miso_oe),
    .sck_event(sck_event), .irq(irq));
  sbp_spi_master u_sbp_spi_master (.clk(clk), .mode(mode_cfg), .lsb_first(lsb_cfg),
    .sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso_line));
  // undriven data out line keeps changing
  always @(posedge clk) miso_float <= ~miso_float;
  assign miso_line = miso_oe ? miso_out : miso_float;
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ra(input logic [2:0] idx);
    return {27'h0, idx, 2'h0};
  endfunction : ra
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] wd,
      output logic [7:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, ra(idx), d, r, e);
  endtask : wr
  task automatic rc(input string what, input logic [2:0] idx, input logic [7:0] exp,
      input logic [7:0] m);
    logic [7:0] r;
    logic e;
    apb(1'b0, ra(idx), 8'h00, r, e);
    chk(what, exp & m, r & m);
  endtask : rc
  //////////////////////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [7:0] r;
    logic e;
    rc("control_a reset", CA, sbp_pkg::RST_CONTROL_A, 8'hFF);
    rc("control_b reset", CB, sbp_pkg::RST_CONTROL_B, 8'hFF);
    rc("irq_enable reset", IE, sbp_pkg::RST_IRQ_ENABLE, 8'hFF);
    rc("flags reset", FL, 8'h00, 8'hFF);
    wr(CB, 8'hFF);
    rc("control_b bits", CB, 8'hC7, 8'hFF);
    wr(CB, 8'h00);
    wr(IE, 8'hFF);
    rc("irq_enable bits", IE, 8'hF1, 8'hFF);
    wr(IE, 8'h00);
    wr(CA, 8'hFF);
    rc("control_a bits", CA, 8'h77, 8'hFF);
    wr(CA, 8'h00);
    apb(1'b0, 32'h0000_0014, 8'h00, r, e);
    chk("unmapped error", 8'h01, {7'h0, e});
    chk("unmapped data", 8'h00, r);
  endtask : test_regs
  task automatic test_wait0();
    logic [7:0] r;
    wr(CB, 8'h80);
    wr(IE, 8'h80);
    wr(CA, 8'h01);
    miso_dir_out <= 1'b1;
    wr(DP, 8'h43);
    rc("flags after write", FL, 8'h00, 8'hFF);
    u_sbp_spi_master.xfer(8'h11, 8, r);
    chk("dummy byte", 8'h00, r);
    rc("flags after dummy", FL, 8'hA0, 8'hFF);
    wr(DP, 8'h44);
    wr(DP, 8'h45);
    rc("flags while full", FL, 8'h80, 8'hFF);
    u_sbp_spi_master.xfer(8'h22, 8, r);
    chk("first user byte", 8'h43, r);
    u_sbp_spi_master.xfer(8'h33, 8, r);
    chk("second user byte", 8'h44, r);
    rc("flags after overflow", FL, 8'hE1, 8'hFF);
    chk("irq with data", 8'h01, {7'h0, irq});
    rc("oldest byte", DP, 8'h11, 8'hFF);
    rc("flags after read", FL, 8'hE0, 8'hFF);
    rc("second byte", DP, 8'h22, 8'hFF);
    rc("flags when drained", FL, 8'h60, 8'hFF);
    chk("irq drained", 8'h00, {7'h0, irq});
    wr(FL, 8'h40);
    rc("flags after clear", FL, 8'h20, 8'hFF);
  endtask : test_wait0
  task automatic test_modes();
    logic [7:0] r, tx;
    for (int m = 0; m < 4; m++) begin
      for (int o = 0; o < 2; o++) begin
        tx = {3'h5, 2'(m), 1'(o), 2'h1};
        mode_cfg = 2'(m);
        lsb_cfg = 1'(o);
        wr(CA, 8'h00);
        wr(CB, {6'h30, 2'(m)});
        wr(CA, {1'b0, 1'(o), 5'h00, 1'b1});
        wr(DP, tx);
        u_sbp_spi_master.xfer(~tx, 8, r);
        chk("byte shifted out", tx, r);
        rc("byte shifted in", DP, ~tx, 8'hFF);
      end
    end
  endtask : test_modes
  task automatic test_abort();
    logic [7:0] r;
    mode_cfg = 2'h0;
    lsb_cfg = 1'b0;
    wr(CA, 8'h00);
    wr(CB, 8'hC0);
    wr(CA, 8'h01);
    wr(DP, 8'hC3);
    u_sbp_spi_master.xfer(8'h0F, 4, r);
    rc("nothing after abort", FL, 8'h00, 8'h80);
    u_sbp_spi_master.xfer(8'h96, 8, r);
    rc("realigned byte", DP, 8'h96, 8'hFF);
  endtask : test_abort
  task automatic test_drop();
    logic [7:0] r;
    wr(CA, 8'h00);
    wr(CB, 8'h00);
    wr(CA, 8'h01);
    wr(DP, 8'h5A);
    u_sbp_spi_master.xfer(8'hA5, 8, r);
    chk("normal byte out", 8'h5A, r);
    rc("normal flag", FL, 8'h80, 8'hFF);
    rc("normal byte in", DP, 8'hA5, 8'hFF);
    miso_dir_out <= 1'b0;
    wr(IE, 8'h01);
    wr(CA, 8'h21);
    u_sbp_spi_master.select_low(20);
    rc("controller dropped", CA, 8'h01, 8'hFF);
    rc("transfer flag", FL, 8'h80, 8'h80);
    chk("irq raised", 8'h01, {7'h0, irq});
    wr(FL, 8'h80);
    rc("flag cleared", FL, 8'h00, 8'h80);
    chk("irq released", 8'h00, {7'h0, irq});
    wr(CB, 8'h04);
    wr(CA, 8'h21);
    u_sbp_spi_master.select_low(20);
    rc("select ignored", CA, 8'h21, 8'hFF);
  endtask : test_drop
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    miso_dir_out = 1'b0;
    miso_float = 1'b0;
    mode_cfg = 2'h0;
    lsb_cfg = 1'b0;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    test_regs();
    test_wait0();
    test_modes();
    test_abort();
    test_drop();
    end_sim();
  end
endmodule : tb
`default_nettype wire
